/* core/tcic_timer.sv */
// Main timer: free-running counter, capture/compare channels, port pin sharing,
// accumulator, periodic tick and watchdog, behind an AHB-Lite slave.
// Assumes pin inputs synchronous to hclk and a single-slave bus (zero wait states).
`timescale 1ns/1ps
module tcic_timer
  import tcic_pkg::*;
#(
  parameter int unsigned WD_DIV_LOG2  = 15,
  parameter int unsigned WD_LIMIT     = 4,
  parameter int unsigned RTI_LOG2     = 13,
  parameter int unsigned GATE_LOG2    = 6,
  parameter int unsigned RST_PULSE    = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [7:0]       pin_in,
  output tcic_port_t            port,
  output logic      [F_W-1:0]   irq_req,
  output logic                  rst_pin_out,
  output logic                  rst_pin_oe
);
  function automatic logic edge_hit(input logic [1:0] code, input logic prev, input logic cur);
    edge_hit = (code == E_RISE && !prev && cur) || (code == E_FALL && prev && !cur) ||
               (code == E_ANY && prev != cur);
  endfunction : edge_hit

  function automatic logic tap(input logic [15:0] c, input int unsigned n);
    logic [16:0] m;
    m = (17'h1 << n) - 17'h1;
    tap = (c & m[15:0]) == m[15:0];
  endfunction : tap

  logic [2:0]     ctrl_reg;
  logic [5:0]     accc_reg;
  logic [7:0]     edge_reg;
  logic [F_W-1:0] ien_reg;
  logic [F_W-1:0] flag_reg;
  logic [F_W-1:0] flag_next;
  logic [15:0]    cnt_reg;
  logic [3:0]     pre_reg;
  logic           upd_reg;
  logic [15:0]    cap_reg [3];
  logic [15:0]    shr_reg;
  logic [15:0]    cmp_reg [4];
  logic [7:0]     pdat_reg;
  logic [7:0]     dir_reg;
  logic [7:0]     act_reg;
  logic [7:0]     oc1m_reg;
  logic [7:0]     oc1d_reg;
  logic [7:3]     oc_reg;
  logic [7:3]     oc_next;
  logic [7:0]     acnt_reg;
  logic [15:0]    chain_reg;
  logic [7:0]     wdc_reg;
  logic           wkey_reg;
  logic [7:0]     rstc_reg;
  logic [4:0]     s1_reg;
  logic [4:0]     s2_reg;
  logic [4:0]     s3_reg;
  logic [3:0]     pend_reg;
  logic [3:0]     hold_reg;
  logic           wr_reg;
  logic [7:0]     wa_reg;
  logic [31:0]    rd_val;
  logic [3:0]     hit;
  logic [3:0]     go;
  logic [7:0]     owned;

  // Bus decode; slave never stalls and always answers OKAY
  wire       req_ok = hsel && htrans[1] && hready;
  wire       rd_a   = req_ok && !hwrite;
  wire [7:0] ra     = haddr[7:0];
  wire [7:0] wdb    = hwdata[7:0];
  wire       w_ctrl = wr_reg && wa_reg == A_CTRL;
  wire       w_edge = wr_reg && wa_reg == A_EDGE;
  wire       w_ien  = wr_reg && wa_reg == A_IEN;
  wire       w_flag = wr_reg && wa_reg == A_FLAG;
  wire       w_shr  = wr_reg && wa_reg == A_SHR;
  wire       w_port = wr_reg && wa_reg == A_PORT;
  wire       w_dir  = wr_reg && wa_reg == A_DIR;
  wire       w_act  = wr_reg && wa_reg == A_ACT;
  wire       w_oc1  = wr_reg && wa_reg == A_OC1;
  wire       w_acc  = wr_reg && wa_reg == A_ACC;
  wire       w_acnt = wr_reg && wa_reg == A_ACNT;
  wire       w_wdog = wr_reg && wa_reg == A_WDOG;
  wire [3:0] w_cmp  = {wr_reg && wa_reg == A_CMP4, wr_reg && wa_reg == A_CMP3,
                       wr_reg && wa_reg == A_CMP2, wr_reg && wa_reg == A_CMP1};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // prescaler terminal count per select code
  wire [1:0] psel   = ctrl_reg[C_PS +: 2];
  wire [3:0] ps_lim = psel == 2'h0 ? PS_DIV1 : psel == 2'h1 ? PS_DIV4 :
                      psel == 2'h2 ? PS_DIV8 : PS_DIV16;
  wire       tick   = pre_reg >= ps_lim;
  wire       sel4   = accc_reg[P_SEL];

  // capture four watches the driven level when pin 3 is an output
  wire cap4_src = port.oe[3] ? port.out[3] : pin_in[3];
  wire [4:0] src = {pin_in[7], cap4_src, pin_in[0], pin_in[1], pin_in[2]};
  wire [1:0] efld [4];
  assign efld[0] = edge_reg[5:4];
  assign efld[1] = edge_reg[3:2];
  assign efld[2] = edge_reg[1:0];
  assign efld[3] = edge_reg[7:6];

  // edge detection on synchronised samples only
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit[i] = edge_hit(efld[i], s3_reg[i], s2_reg[i]) && (i != 3 || sel4);
    end
  end
  // a capture that meets a read hold stays pending until the next cycle
  assign go = (pend_reg | hit) & ~hold_reg;

  // compare matches evaluated the cycle after the counter changes
  wire [3:0] m_cmp;
  assign m_cmp[0] = upd_reg && cnt_reg == cmp_reg[0];
  assign m_cmp[1] = upd_reg && cnt_reg == cmp_reg[1];
  assign m_cmp[2] = upd_reg && cnt_reg == cmp_reg[2];
  assign m_cmp[3] = upd_reg && cnt_reg == cmp_reg[3];
  wire       m5   = upd_reg && !sel4 && cnt_reg == shr_reg;
  wire [6:3] pm   = {m_cmp[1], m_cmp[2], m_cmp[3], m5};

  // compare one acts after the dedicated channel so it takes priority
  always_comb begin
    oc_next = oc_reg;
    for (int p = 3; p < 7; p++) begin
      if (pm[p]) begin
        case (act_reg[2*(p-3) +: 2])
          M_TOG:   oc_next[p] = !oc_reg[p];
          M_CLR:   oc_next[p] = 1'b0;
          M_SET:   oc_next[p] = 1'b1;
          default: oc_next[p] = oc_reg[p];
        endcase
      end
    end
    for (int p = 3; p < 8; p++) begin
      if (m_cmp[0] && oc1m_reg[p]) begin
        oc_next[p] = oc1d_reg[p];
      end
    end
  end

  // pin ownership; owned pins ignore port data
  always_comb begin
    owned = 8'h00;
    for (int p = 3; p < 7; p++) begin
      owned[p] = (act_reg[2*(p-3) +: 2] != 2'h0 && (p != 3 || !sel4)) || oc1m_reg[p];
    end
    owned[7] = oc1m_reg[7];
  end
  assign port.out = (owned & {oc_reg, 3'h0}) | (~owned & pdat_reg);
  assign port.oe  = owned | dir_reg;

  wire pol  = accc_reg[P_POL];
  wire ahit = pol ? (s2_reg[4] && !s3_reg[4]) : (!s2_reg[4] && s3_reg[4]);
  wire ainc = accc_reg[P_EN] && (accc_reg[P_GATE] ? tap(chain_reg, GATE_LOG2) && s2_reg[4] == pol
                                                  : ahit);
  // periodic tick from one of four chain taps
  wire pir  = tap(chain_reg, RTI_LOG2 + 32'(accc_reg[P_RATE +: 2]));
  // watchdog clocked by bus clock over 2^15
  wire wtick = ctrl_reg[C_WDEN] && tap(chain_reg, WD_DIV_LOG2);
  wire wserv = w_wdog && wkey_reg && wdb == WD_KEY2;
  wire wfire = wtick && !wserv && wdc_reg == 8'(WD_LIMIT - 1);

  // Flag sets win over a software clear in the same cycle
  always_comb begin
    flag_next = flag_reg & ~(w_flag ? hwdata[F_W-1:0] : '0);
    flag_next[F_CAP1 +: 3] |= go[2:0];
    flag_next[F_C4C5]      |= go[3] || m5;
    flag_next[F_CMP1 +: 4] |= m_cmp;
    flag_next[F_OVF]       |= tick && cnt_reg == 16'hFFFF;
    flag_next[F_PIR]       |= pir;
    flag_next[F_AOVF]      |= ainc && acnt_reg == 8'hFF;
    flag_next[F_AEDG]      |= accc_reg[P_EN] && ahit;
  end
  // one request per function, level while flag and enable are set
  assign irq_req = flag_reg & ien_reg;

  always_comb begin
    case (ra)
      A_CTRL:  rd_val = {29'h0, ctrl_reg};
      A_EDGE:  rd_val = {24'h0, edge_reg};
      A_IEN:   rd_val = {20'h0, ien_reg};
      A_FLAG:  rd_val = {20'h0, flag_reg};
      A_CNT:   rd_val = {16'h0, cnt_reg};
      A_CAP1:  rd_val = {16'h0, cap_reg[0]};
      A_CAP2:  rd_val = {16'h0, cap_reg[1]};
      A_CAP3:  rd_val = {16'h0, cap_reg[2]};
      A_SHR:   rd_val = {16'h0, shr_reg};
      A_CMP1:  rd_val = {16'h0, cmp_reg[0]};
      A_CMP2:  rd_val = {16'h0, cmp_reg[1]};
      A_CMP3:  rd_val = {16'h0, cmp_reg[2]};
      A_CMP4:  rd_val = {16'h0, cmp_reg[3]};
      // pin levels readable regardless of function
      A_PORT:  rd_val = {24'h0, pin_in};
      A_DIR:   rd_val = {24'h0, dir_reg};
      A_ACT:   rd_val = {24'h0, act_reg};
      A_OC1:   rd_val = {16'h0, oc1d_reg, oc1m_reg};
      A_ACC:   rd_val = {26'h0, accc_reg};
      A_ACNT:  rd_val = {24'h0, acnt_reg};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg   <= 1'b0;
      wa_reg   <= 8'h00;
      hrdata   <= 32'h0;
      hold_reg <= 4'h0;
    end else begin
      wr_reg   <= req_ok && hwrite;
      wa_reg   <= ra;
      hrdata   <= rd_a ? rd_val : 32'h0;
      // read of a capture register holds its transfer for one cycle
      hold_reg <= {rd_a && ra == A_SHR, rd_a && ra == A_CAP3, rd_a && ra == A_CAP2, rd_a && ra == A_CAP1};
    end
  end

  // counter has no load, clear or stop path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg   <= 4'h0;
      cnt_reg   <= 16'h0;
      upd_reg   <= 1'b0;
      chain_reg <= 16'h0;
    end else begin
      pre_reg   <= tick ? 4'h0 : pre_reg + 4'h1;
      cnt_reg   <= tick ? cnt_reg + 16'h1 : cnt_reg;
      upd_reg   <= tick;
      chain_reg <= chain_reg + 16'h1;
    end
  end

  // two-stage sync, edges seen between stages two and three
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg   <= 5'h0;
      s2_reg   <= 5'h0;
      s3_reg   <= 5'h0;
      pend_reg <= 4'h0;
    end else begin
      s1_reg   <= src;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      pend_reg <= (pend_reg | hit) & hold_reg;
    end
  end

  // capture latches hold the stable counter; not cleared by reset
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 3; i++) begin
      if (go[i]) begin
        cap_reg[i] <= cnt_reg;
      end
    end
  end

  // select, direction and shared register reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 3'h0;
      accc_reg <= 6'h0;
      edge_reg <= 8'h00;
      ien_reg  <= '0;
      flag_reg <= '0;
      shr_reg  <= CMP_RST;
      for (int i = 0; i < 4; i++) begin
        cmp_reg[i] <= CMP_RST;
      end
      pdat_reg <= 8'h00;
      dir_reg  <= 8'h00;
      act_reg  <= 8'h00;
      oc1m_reg <= 8'h00;
      oc1d_reg <= 8'h00;
      oc_reg   <= 5'h00;
    end else begin
      if (w_ctrl) ctrl_reg <= hwdata[2:0];
      if (w_acc)  accc_reg <= hwdata[5:0];
      if (w_edge) edge_reg <= wdb;
      if (w_ien)  ien_reg  <= hwdata[F_W-1:0];
      flag_reg <= flag_next;
      // writes ignored while capture four owns the register
      if (go[3]) begin
        shr_reg <= cnt_reg;
      end else if (w_shr && !sel4) begin
        shr_reg <= hwdata[15:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (w_cmp[i]) cmp_reg[i] <= hwdata[15:0];
      end
      if (w_port) pdat_reg <= wdb;
      if (w_dir)  dir_reg  <= wdb;
      if (w_act)  act_reg  <= wdb;
      if (w_oc1) begin
        oc1m_reg <= {wdb[7:3], 3'h0};
        oc1d_reg <= {hwdata[OC1_DATA+7 -: 5], 3'h0};
      end
      oc_reg <= oc_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acnt_reg <= 8'h00;
      wdc_reg  <= 8'h00;
      wkey_reg <= 1'b0;
      rstc_reg <= 8'h00;
    end else begin
      acnt_reg <= w_acnt ? wdb : acnt_reg + 8'(ainc);
      if (w_wdog) wkey_reg <= wdb == WD_KEY1;
      wdc_reg  <= (wserv || wfire) ? 8'h00 : wdc_reg + 8'(wtick);
      rstc_reg <= wfire ? 8'(RST_PULSE) : rstc_reg - 8'(rstc_reg != 8'h00);
    end
  end
  // open-drain reset pin, only ever pulled low
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = rstc_reg != 8'h00;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_match5;
    m5 && act_reg[1:0] == M_SET && !m_cmp[0];
  endsequence
  sequence s_pin_set;
    ##1 oc_reg[3] && port.out[3];
  endsequence

  chk_count_step: assert property (tick |=> cnt_reg == $past(cnt_reg) + 16'h1)
    else $error("counter did not step on tick");
  chk_count_wrap: assert property (tick && cnt_reg == 16'hFFFF |=> cnt_reg == 16'h0 && flag_reg[F_OVF])
    else $error("wrap without overflow flag");
  chk_prescale_div16: assert property (tick && psel == 2'h3 ##1 psel == 2'h3 [*8] |-> !tick [*1])
    else $error("divide by sixteen ticked early");
  chk_capture_value: assert property (go[0] |=> cap_reg[0] == $past(cnt_reg))
    else $error("capture latched wrong count");
  chk_capture_hold: assert property (hit[1] && hold_reg[1] |=> go[1] && $stable(cap_reg[1]))
    else $error("held capture not delayed one cycle");
  chk_shared_write: assert property (w_shr && sel4 && !go[3] |=> $stable(shr_reg))
    else $error("shared register written in capture mode");
  chk_compare_pin: assert property (s_match5 |-> s_pin_set)
    else $error("compare five pin not set after match");
  chk_owned_pin: assert property (owned[4] |-> port.out[4] == oc_reg[4] && port.oe[4])
    else $error("owned pin follows port data");
  chk_irq_level: assert property (flag_reg[F_OVF] && ien_reg[F_OVF] |-> irq_req[F_OVF])
    else $error("overflow request missing");
  chk_wdog_fire: assert property (wfire |=> rst_pin_oe [*8])
    else $error("watchdog reset pulse too short");
  chk_pin3_capture: assert property (sel4 && port.oe[3] && $changed(port.out[3]) && edge_reg[7:6] == E_ANY
                                     |-> ##2 hit[3])
    else $error("pin 3 write did not capture");
endmodule : tcic_timer

/* core/tcic_pkg.sv */
// Constants, register offsets and carrier types for the timer capture/compare block.
// Assumes a single AHB-Lite bus clock; all offsets are byte addresses of aligned words.
package tcic_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_EDGE = 8'h04;
  localparam logic [7:0] A_IEN  = 8'h08;
  localparam logic [7:0] A_FLAG = 8'h0C;
  localparam logic [7:0] A_CNT  = 8'h10;
  localparam logic [7:0] A_CAP1 = 8'h14;
  localparam logic [7:0] A_CAP2 = 8'h18;
  localparam logic [7:0] A_CAP3 = 8'h1C;
  localparam logic [7:0] A_SHR  = 8'h20;
  localparam logic [7:0] A_CMP1 = 8'h24;
  localparam logic [7:0] A_CMP2 = 8'h28;
  localparam logic [7:0] A_CMP3 = 8'h2C;
  localparam logic [7:0] A_CMP4 = 8'h30;
  localparam logic [7:0] A_PORT = 8'h34;
  localparam logic [7:0] A_DIR  = 8'h38;
  localparam logic [7:0] A_ACT  = 8'h3C;
  localparam logic [7:0] A_OC1  = 8'h40;
  localparam logic [7:0] A_ACC  = 8'h44;
  localparam logic [7:0] A_ACNT = 8'h48;
  localparam logic [7:0] A_WDOG = 8'h4C;
  // Timer control register fields
  localparam int C_PS   = 0;
  localparam int C_WDEN = 2;
  // Accumulator control register fields
  localparam int P_EN   = 0;
  localparam int P_GATE = 1;
  localparam int P_POL  = 2;
  localparam int P_RATE = 3;
  localparam int P_SEL  = 5;
  // Flag / enable / request bit positions
  localparam int F_CAP1 = 0;
  localparam int F_C4C5 = 3;
  localparam int F_CMP1 = 4;
  localparam int F_OVF  = 8;
  localparam int F_PIR  = 9;
  localparam int F_AOVF = 10;
  localparam int F_AEDG = 11;
  localparam int F_W    = 12;
  localparam int OC1_DATA = 8;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [7:0]  WD_KEY1 = 8'h55;
  localparam logic [7:0]  WD_KEY2 = 8'hAA;
  localparam logic [1:0]  E_RISE  = 2'h1;
  localparam logic [1:0]  E_FALL  = 2'h2;
  localparam logic [1:0]  E_ANY   = 2'h3;
  localparam logic [1:0]  M_TOG   = 2'h1;
  localparam logic [1:0]  M_CLR   = 2'h2;
  localparam logic [1:0]  M_SET   = 2'h3;
  localparam logic [3:0]  PS_DIV1  = 4'h0;
  localparam logic [3:0]  PS_DIV4  = 4'h3;
  localparam logic [3:0]  PS_DIV8  = 4'h7;
  localparam logic [3:0]  PS_DIV16 = 4'hF;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } tcic_port_t;
endpackage : tcic_pkg

/* tb/tcic_pin_src.sv */
// Pin source model: external drivers on the eight timer port pins.
// Assumes port.oe marks the pins the block drives; those pins read back port.out.
`timescale 1ns/1ps
module tcic_pin_src
  import tcic_pkg::*;
(
  input  wire logic [7:0] ext_lvl,
  input  wire tcic_port_t port,
  output logic      [7:0] pin_lvl
);
  // resolved pin level
  // Driven pins echo the block, so port data writes can raise capture edges
  assign pin_lvl = (port.oe & port.out) | (~port.oe & ext_lvl);
endmodule : tcic_pin_src

/* tb/test_tcic_timer.sv */
// Testbench for the timer block: reset map, counter, captures, compares, pins, watchdog.
// Assumes hready tied to hreadyout and the pin source model closing the port pin loop.
`timescale 1ns/1ps
module test_tcic_timer
  import tcic_pkg::*;
();
  typedef struct {logic [7:0] a; logic [31:0] v;} tcic_row_t;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, rst_pin_out, rst_pin_oe;
  logic      [31:0] haddr, hwdata, hrdata, rd;
  logic      [1:0]  htrans;
  logic      [2:0]  hsize;
  logic      [7:0]  ext_lvl, pin_lvl;
  logic      [15:0] c0, dl;
  logic [F_W-1:0]   irq_req;
  tcic_port_t       port;
  int               num_errors, num_checks, cycles, m;
  int               div [4] = '{1, 4, 8, 16};
  tcic_row_t        rows [14] = '{'{A_CTRL, 32'h0}, '{A_EDGE, 32'h0}, '{A_IEN, 32'h0}, '{A_FLAG, 32'h0},
    '{A_SHR, 32'hFFFF}, '{A_CMP1, 32'hFFFF}, '{A_CMP2, 32'hFFFF}, '{A_CMP3, 32'hFFFF}, '{A_CMP4, 32'hFFFF},
    '{A_DIR, 32'h0}, '{A_ACT, 32'h0}, '{A_ACC, 32'h0}, '{A_OC1, 32'h0}, '{8'h80, 32'h0}};

  tcic_timer #(.WD_DIV_LOG2(4), .WD_LIMIT(2), .RTI_LOG2(3), .GATE_LOG2(2)) i_tcic_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_lvl), .port(port), .irq_req(irq_req), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe));
  tcic_pin_src i_tcic_pin_src (.ext_lvl(ext_lvl), .port(port), .pin_lvl(pin_lvl));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // Single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Overflow wait dominates the run at about 66k cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    ext_lvl = 8'h0;
    cyc(8);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].v, "reset value");
    end
    done("reset map");
    foreach (div[k]) begin
      bus(1'b1, A_CTRL, 32'(k));
      bus(1'b0, A_CNT, 32'h0);
      c0 = rd[15:0];
      cyc(158);
      bus(1'b0, A_CNT, 32'h0);
      dl = rd[15:0] - c0;
      check(32'(dl >= 16'(160 / div[k] - 1) && dl <= 16'(160 / div[k] + 1)), 32'h1, "rate");
    end
    bus(1'b1, A_CTRL, 32'h0);
    bus(1'b0, A_CNT, 32'h0);
    c0 = rd[15:0];
    bus(1'b1, A_CNT, 32'h0);
    bus(1'b0, A_CNT, 32'h0);
    check(32'(rd[15:0] - c0), 32'h4, "counter load");
    done("prescaler");
    for (m = 0; m < 4; m++) begin
      bus(1'b1, A_EDGE, 32'(m << 4));
      bus(1'b1, A_FLAG, 32'hFFF);
      bus(1'b0, A_CNT, 32'h0);
      c0 = rd[15:0];
      ext_lvl[2] <= 1'b1;
      cyc(8);
      bus(1'b0, A_FLAG, 32'h0);
      check(32'(rd[F_CAP1]), 32'(m == 1 || m == 3), "rise capture");
      if (m[0]) begin
        bus(1'b0, A_CAP1, 32'h0);
        dl = rd[15:0] - c0;
        check(32'(dl >= 16'h1 && dl <= 16'hC), 32'h1, "capture value");
      end
      bus(1'b1, A_FLAG, 32'hFFF);
      ext_lvl[2] <= 1'b0;
      cyc(8);
      bus(1'b0, A_FLAG, 32'h0);
      check(32'(rd[F_CAP1]), 32'(m >= 2), "fall capture");
    end
    // Pin edge timed so its detection meets the read hold of capture two
    bus(1'b1, A_EDGE, 32'h3C);
    bus(1'b0, A_CNT, 32'h0);
    c0 = rd[15:0];
    ext_lvl[1] <= 1'b1;
    cyc(1);
    bus(1'b0, A_CAP2, 32'h0);
    cyc(4);
    bus(1'b0, A_CAP2, 32'h0);
    check(32'(rd[15:0] - c0), 32'h5, "held capture");
    done("capture edges");
    bus(1'b1, A_FLAG, 32'hFFF);
    ext_lvl[2] <= 1'b1;
    cyc(8);
    check(32'(irq_req), 32'h0, "masked request");
    bus(1'b1, A_IEN, 32'h1);
    cyc(2);
    check(32'(irq_req), 32'h1, "own request");
    bus(1'b1, A_FLAG, 32'h1);
    cyc(2);
    check(32'(irq_req), 32'h0, "request cleared");
    bus(1'b1, A_IEN, 32'h0);
    for (m = 0; m < 4; m++) begin
      bus(1'b1, A_ACC, 32'(m << P_RATE));
      bus(1'b1, A_FLAG, 32'hFFF);
      cyc(2 ** (4 + m));
      bus(1'b0, A_FLAG, 32'h0);
      check(32'(rd[F_PIR]), 32'h1, "periodic tick");
    end
    done("requests");
    bus(1'b1, A_ACNT, 32'h0);
    bus(1'b1, A_ACC, 32'h5);
    repeat (3) begin
      ext_lvl[7] <= 1'b1;
      cyc(4);
      ext_lvl[7] <= 1'b0;
      cyc(4);
    end
    bus(1'b0, A_ACNT, 32'h0);
    check(rd, 32'h3, "event count");
    bus(1'b1, A_ACC, 32'h7);
    bus(1'b1, A_ACNT, 32'h0);
    ext_lvl[7] <= 1'b1;
    cyc(64);
    ext_lvl[7] <= 1'b0;
    cyc(4);
    bus(1'b0, A_ACNT, 32'h0);
    check(32'(rd >= 32'hE && rd <= 32'h12), 32'h1, "gated count");
    ext_lvl[3:0] <= 4'h5;
    cyc(2);
    bus(1'b0, A_PORT, 32'h0);
    check(32'(rd[3:0]), 32'h5, "pin levels");
    ext_lvl[3:0] <= 4'h0;
    done("accumulator");
    bus(1'b1, A_ACC, 32'h0);
    bus(1'b1, A_SHR, 32'h1234);
    bus(1'b0, A_SHR, 32'h0);
    check(rd, 32'h1234, "compare five write");
    bus(1'b1, A_ACC, 32'h20);
    bus(1'b1, A_SHR, 32'h5555);
    bus(1'b0, A_SHR, 32'h0);
    check(rd, 32'h1234, "capture four write");
    bus(1'b1, A_EDGE, 32'hC0);
    bus(1'b1, A_DIR, 32'h8);
    bus(1'b1, A_FLAG, 32'hFFF);
    bus(1'b1, A_PORT, 32'h8);
    cyc(8);
    bus(1'b0, A_FLAG, 32'h0);
    check(32'(rd[F_C4C5]), 32'h1, "port write capture");
    check(32'({port.oe[3], port.out[3]}), 32'h3, "pin 3 driven");
    done("shared channel");
    bus(1'b1, A_ACC, 32'h0);
    bus(1'b1, A_DIR, 32'h80);
    bus(1'b1, A_PORT, 32'h0);
    bus(1'b1, A_OC1, 32'h8080);
    bus(1'b1, A_ACT, 32'hC3);
    bus(1'b0, A_CNT, 32'h0);
    c0 = rd[15:0] + 16'h28;
    bus(1'b1, A_CMP1, 32'(c0));
    bus(1'b1, A_CMP2, 32'(c0));
    // One count after compare one, so compare five acts on pin 3 alone
    bus(1'b1, A_SHR, 32'(c0 + 16'h1));
    cyc(50);
    check(32'({port.oe[7:6], port.out[7:6]}), 32'hF, "compare pins");
    check(32'({port.oe[3], port.out[3]}), 32'h3, "compare five pin");
    bus(1'b1, A_PORT, 32'h0);
    cyc(2);
    check(32'(port.out[7]), 32'h1, "port write blocked");
    bus(1'b0, A_FLAG, 32'h0);
    check(32'(rd[5:4]), 32'h3, "compare flags");
    done("compares");
    bus(1'b1, A_FLAG, 32'hFFF);
    m = 0;
    do begin
      bus(1'b0, A_FLAG, 32'h0);
      m++;
    end while (rd[F_OVF] !== 1'b1 && m < 40000);
    bus(1'b0, A_CNT, 32'h0);
    check(32'(rd[15:0] < 16'h10), 32'h1, "wrap to zero");
    done("overflow");
    bus(1'b1, A_CTRL, 32'h4);
    repeat (10) begin
      bus(1'b1, A_WDOG, 32'(WD_KEY1));
      bus(1'b1, A_WDOG, 32'(WD_KEY2));
      cyc(6);
      check(32'(rst_pin_oe), 32'h0, "serviced watchdog");
    end
    m = 0;
    while (rst_pin_oe !== 1'b1 && m < 300) begin
      cyc(1);
      m++;
    end
    check(32'({rst_pin_oe, rst_pin_out}), 32'h2, "watchdog reset");
    done("watchdog");
    hresetn <= 1'b0;
    cyc(8);
    hresetn <= 1'b1;
    check(32'({rst_pin_oe, port.oe, irq_req}), 32'h0, "outputs in reset");
    bus(1'b0, A_SHR, 32'h0);
    check(rd, 32'hFFFF, "shared reset");
    done("second reset");
    wrap_up();
  end
endmodule : test_tcic_timer
